// file: ptt_cpu_model.sv
`timescale 1ns/1ns
module ptt_cpu_model (
    input wire i_core_clk, // clk
    input wire [7:0] i_rdata, // read data
    output reg [11:0] o_addr, // addr
    output reg o_wr, // wr
    output reg o_rd, // rd
    output reg [7:0] o_wdata // wdata
);
initial {o_addr, o_wr, o_rd, o_wdata} = 22'h0;
// plain single loads and stores only, never reserved places
task xfer(input w, input [11:0] a, input [7:0] d, output [7:0] q);
    @(negedge i_core_clk);
    {o_addr, o_wdata, o_wr, o_rd} = {a, d, w, !w};
    @(negedge i_core_clk);
    q = i_rdata;
    {o_addr, o_wdata, o_wr, o_rd} = {~a, ~d, 2'b00};
endtask
endmodule

// file: ptt_defines.vh
// Notes on behaviour
// R1: control bit3 enable, bits2..0 rate, reset zero
// R2: tick requests only while enable is one
// R3: fast source taps 23,21,16,14,13,12,11,9
// R4: slow source taps 15,13,8,6,5,4,3,1
// R5: slow/sleep modes: only codes 000, 001 valid; the timer does not block the other codes, which use the low-source taps
// R6: software changes rate only while disabled
// R7: one write may set rate and enable
// R8: tick on each falling edge of tap
// R9: divider never cleared by enable or write
// R10: special space 0000-003F, buffer 0F80-0FFF
// R11: software never touches reserved addresses
// R12: no read-modify-write on write-only registers
// R13: falling edge pulses request, latch sets
`ifndef PTT_DEFINES_VH
`define PTT_DEFINES_VH
`define PTT_ADDR_W 12
`define PTT_CTRL_ADDR 12'h036
`define PTT_SFR_LAST 12'h03F
`define PTT_DBR_FIRST 12'hF80
`define PTT_CTRL_RESET 8'h00
`define PTT_EN_BIT 3
`define PTT_RATE_HI 2
`define PTT_RATE_LO 0
`define PTT_DIV_W 23
`define PTT_FAST_T0 5'd22
`define PTT_FAST_T1 5'd20
`define PTT_FAST_T2 5'd15
`define PTT_FAST_T3 5'd13
`define PTT_FAST_T4 5'd12
`define PTT_FAST_T5 5'd11
`define PTT_FAST_T6 5'd10
`define PTT_FAST_T7 5'd8
`define PTT_SLOW_T0 5'd14
`define PTT_SLOW_T1 5'd12
`define PTT_SLOW_T2 5'd7
`define PTT_SLOW_T3 5'd5
`define PTT_SLOW_T4 5'd4
`define PTT_SLOW_T5 5'd3
`define PTT_SLOW_T6 5'd2
`define PTT_SLOW_T7 5'd0
`endif

// file: ptt_monitor.sv
`timescale 1ns/1ns
module ptt_monitor (
    input wire i_core_clk, // clk
    input wire i_rst, // rst
    input wire [11:0] i_addr, // addr
    input wire i_wr, // wr
    input wire i_rd, // rd
    input wire [7:0] i_wdata, // wdata
    input wire i_tick_interrupt_clear, // clr
    input wire [7:0] o_rdata, // rdata
    input wire o_tick_interrupt, // latch
    input wire o_tick_request // pulse
);
reg [7:0] ctl_q;
wire sel = i_addr == 12'h036;
always @(posedge i_core_clk)
    if (i_rst)
        ctl_q <= 8'h00;
    else if (i_wr && sel)
        ctl_q <= i_wdata;
default clocking @(posedge i_core_clk); endclocking
default disable iff (i_rst);
sequence s_rd_ctl;
    i_rd && sel && !i_wr;
endsequence
a_req_enabled: assert property (o_tick_request |->
    ctl_q[3] || $past(ctl_q[3])) else $error("tick while off");
a_req_pulse: assert property (o_tick_request |=>
    !o_tick_request) else $error("request too long");
a_req_latch: assert property (o_tick_request |->
    o_tick_interrupt) else $error("latch not set");
a_latch_holds: assert property (o_tick_interrupt &&
    !i_tick_interrupt_clear |=> o_tick_interrupt) else $error("lost");
a_latch_clear: assert property ($fell(o_tick_interrupt) |->
    $past(i_tick_interrupt_clear)) else $error("latch dropped");
a_latch_cause: assert property ($rose(o_tick_interrupt) |->
    o_tick_request) else $error("latch without tick");
a_read_back: assert property (s_rd_ctl |=>
    o_rdata == $past(ctl_q)) else $error("bad read data");
a_read_other: assert property (!(i_rd && sel) |=>
    o_rdata == 8'h00) else $error("stray read data");
endmodule
bind ptt_timer ptt_monitor MON (.*);

// file: ptt_timer.v
`timescale 1ns/1ns
`include "ptt_defines.vh"
module ptt_timer (
    input wire i_core_clk, // core clock, 125 MHz
    input wire i_rst, // synchronous reset, active high
    input wire [11:0] i_addr, // cpu byte address
    input wire i_wr, // write strobe, one cycle
    input wire i_rd, // read strobe
    input wire [7:0] i_wdata, // write data
    input wire i_high_freq_clock_tick, // one pulse per high clock period
    input wire i_low_freq_clock_tick, // one pulse per low clock period
    input wire i_prescaler_source_select, // 1: low clock in normal
    input wire i_slow_operation, // slow or sleep mode active
    input wire i_tick_interrupt_clear, // controller clears latch
    output reg [7:0] o_rdata, // read data, registered
    output reg o_tick_interrupt, // tick interrupt latch
    output reg o_tick_request // one-cycle request per tick
);
    reg [7:0] ctrl_q;
    reg [7:0] ctrl_d;
    reg [`PTT_DIV_W-1:0] div_q;
    reg [`PTT_DIV_W-1:0] div_d;
    reg tap_q;
    reg req_d;
    reg irq_d;
    reg [7:0] rdata_d;
    wire [`PTT_DIV_W-1:0] carry;
    wire [4:0] idx_now;
    wire [4:0] idx_next;
    wire use_low;
    wire src_tick;
    wire tap_now;
    wire tap_d;
    wire wr_hit;
    wire rd_hit;
    wire enabled;
    wire fall;
    genvar n;

    // field helpers; rate_of serves the live and the next control value, en_of the live one only
    function [2:0] rate_of;
        input [7:0] ctrl;
        begin
            rate_of = ctrl[`PTT_RATE_HI:`PTT_RATE_LO]; // R1
        end
    endfunction

    function en_of;
        input [7:0] ctrl;
        begin
            en_of = ctrl[`PTT_EN_BIT]; // R1
        end
    endfunction

    // a strobe counts only at the control address; reserved space is
    // left alone
    function addr_hit;
        input strobe;
        input [11:0] addr;
        begin
            addr_hit = strobe & (addr == `PTT_CTRL_ADDR); // R10
        end
    endfunction

    // divider bit whose period matches the high clock rate
    function [4:0] fast_tap;
        input [2:0] rate;
        begin
            case (rate)
                3'h0: fast_tap = `PTT_FAST_T0;
                3'h1: fast_tap = `PTT_FAST_T1;
                3'h2: fast_tap = `PTT_FAST_T2;
                3'h3: fast_tap = `PTT_FAST_T3;
                3'h4: fast_tap = `PTT_FAST_T4;
                3'h5: fast_tap = `PTT_FAST_T5;
                3'h6: fast_tap = `PTT_FAST_T6;
                default: fast_tap = `PTT_FAST_T7;
            endcase
        end
    endfunction

    // slow modes define only codes 000 and 001; the other codes are
    // left on the low-source taps rather than blocked
    function [4:0] slow_tap;
        input [2:0] rate;
        begin
            case (rate)
                3'h0: slow_tap = `PTT_SLOW_T0;
                3'h1: slow_tap = `PTT_SLOW_T1;
                3'h2: slow_tap = `PTT_SLOW_T2;
                3'h3: slow_tap = `PTT_SLOW_T3;
                3'h4: slow_tap = `PTT_SLOW_T4;
                3'h5: slow_tap = `PTT_SLOW_T5;
                3'h6: slow_tap = `PTT_SLOW_T6;
                default: slow_tap = `PTT_SLOW_T7;
            endcase
        end
    endfunction

    function [4:0] tap_index;
        input [2:0] rate;
        input low;
        begin
            if (low) begin
                tap_index = slow_tap(rate); // R4 R5
            end else begin
                tap_index = fast_tap(rate); // R3
            end
        end
    endfunction

    // low clock feeds the divider in slow modes or when selected
    assign use_low = i_slow_operation | i_prescaler_source_select;
    assign src_tick = use_low ? i_low_freq_clock_tick
                              : i_high_freq_clock_tick;

    assign wr_hit = addr_hit(i_wr, i_addr); // R10
    assign rd_hit = addr_hit(i_rd, i_addr); // R10

    always @* begin
        ctrl_d = ctrl_q;
        if (wr_hit) begin
            ctrl_d = i_wdata; // R1 R7
        end
    end

    // free-running divider as a carry chain: a bit toggles when the
    // source ticks and all lower bits are one; only reset clears it
    assign carry[0] = src_tick;
    generate
        for (n = 1; n < `PTT_DIV_W; n = n + 1) begin : g_carry
            assign carry[n] = carry[n-1] & div_q[n-1];
        end
    endgenerate

    always @* begin
        div_d = div_q ^ carry; // R9
    end

    // the rate field is used live: a write that enables picks it up
    assign idx_now = tap_index(rate_of(ctrl_q), use_low); // R7
    assign tap_now = div_q[idx_now];
    // the history bit is taken through next cycle's rate, so a write
    // that changes rate and enables together never fakes an edge; a
    // source switch while enabled can still give one early tick
    assign idx_next = tap_index(rate_of(ctrl_d), use_low); // R7 R8
    assign tap_d = div_q[idx_next];
    assign enabled = en_of(ctrl_q);
    assign fall = tap_q & ~tap_now & enabled; // R2 R8

    always @* begin
        req_d = fall; // R13
    end

    // set wins over a clear in the same cycle
    always @* begin
        irq_d = o_tick_interrupt;
        if (fall) begin
            irq_d = 1'h1; // R13
        end else if (i_tick_interrupt_clear) begin
            irq_d = 1'h0;
        end
    end

    // read data is zero outside a read of this register
    always @* begin
        rdata_d = 8'h00;
        if (rd_hit) begin
            rdata_d = ctrl_q;
        end
    end

    always @(posedge i_core_clk) begin
        if (i_rst) begin
            div_q <= {`PTT_DIV_W{1'b0}};
        end else begin
            div_q <= div_d; // R9
        end
    end

    // bits 7..4 are stored and read back but drive nothing here
    always @(posedge i_core_clk) begin
        if (i_rst) begin
            ctrl_q <= `PTT_CTRL_RESET; // R1
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    // tap history follows the tap even while disabled, so enabling
    // never fakes an edge; first tick may come early by design
    always @(posedge i_core_clk) begin
        if (i_rst) begin
            tap_q <= 1'h0;
        end else begin
            tap_q <= tap_d; // R8 R9
        end
    end

    always @(posedge i_core_clk) begin
        if (i_rst) begin
            o_tick_request <= 1'h0;
        end else begin
            o_tick_request <= req_d; // R13
        end
    end

    always @(posedge i_core_clk) begin
        if (i_rst) begin
            o_tick_interrupt <= 1'h0;
        end else begin
            o_tick_interrupt <= irq_d; // R13
        end
    end

    always @(posedge i_core_clk) begin
        if (i_rst) begin
            o_rdata <= 8'h00;
        end else begin
            o_rdata <= rdata_d;
        end
    end
endmodule

// file: ptt_timer_bench.sv
`timescale 1ns/1ns
module ptt_timer_bench;
reg clk = 0, rst = 1, hf = 1, lf = 1, psrc = 0, slow = 0, clr = 0;
wire [11:0] a;
wire wr, rd, irq, req;
wire [7:0] wd, rdata;
reg [7:0] q;
integer failures = 0, n_checks = 0, cyc = 0, k, c;
integer lt[0:7] = '{15, 13, 8, 6, 5, 4, 3, 1};
initial forever #4 clk = ~clk;
ptt_cpu_model CPU (.i_core_clk(clk), .i_rdata(rdata), .o_addr(a),
    .o_wr(wr), .o_rd(rd), .o_wdata(wd));
ptt_timer DUT (.i_core_clk(clk), .i_rst(rst), .i_addr(a), .i_wr(wr),
    .i_rd(rd), .i_wdata(wd), .i_high_freq_clock_tick(hf),
    .i_low_freq_clock_tick(lf), .i_prescaler_source_select(psrc),
    .i_slow_operation(slow), .i_tick_interrupt_clear(clr),
    .o_rdata(rdata), .o_tick_interrupt(irq), .o_tick_request(req));
task check(input string nm, input [31:0] seen, input [31:0] exp);
    n_checks = n_checks + 1;
    if (seen !== exp) begin
        failures = failures + 1;
        $display("CHECK FAILED %s exp %0h seen %0h", nm, exp, seen);
    end
endtask
task give_verdict;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
endtask
// rate and enable go in one write; disabling keeps the rate
task meas(input [7:0] code, input integer t);
    CPU.xfer(1, 12'h036, code, q);
    @(posedge req);
    @(negedge clk);
    k = 0;
    do begin @(negedge clk); k = k + 1; end while (req !== 1'b1);
    check("period", k, 1 << t);
    check("latch", irq, 1);
    clr = 1;
    @(negedge clk) clr = 0;
    check("cleared", irq, 0);
    CPU.xfer(1, 12'h036, code & 8'h07, q);
    $display("rate test %h done", code);
endtask
always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
        failures = failures + 1;
        give_verdict;
    end
end
initial begin
    repeat (4) @(negedge clk);
    rst = 0;
    CPU.xfer(0, 12'h036, 8'h00, q);
    check("reset", q, 8'h00);
    CPU.xfer(1, 12'h036, 8'hF7, q);
    CPU.xfer(0, 12'h036, 8'h00, q);
    check("ctl", q, 8'hF7);
    CPU.xfer(0, 12'h037, 8'h00, q);
    check("other", q, 8'h00);
    k = 0;
    repeat (600) @(negedge clk) k = k + req;
    check("idle ticks", k, 0);
    $display("register test done");
    psrc = 1;
    for (c = 1; c < 8; c = c + 1) meas(8'h08 | c, lt[c]);
    psrc = 0;
    meas(8'h0F, 9);
    meas(8'h0E, 11);
    slow = 1;
    meas(8'h09, 13);
    give_verdict;
end
endmodule
